// ---- rtl/sbgc_pkg.sv ----
// Package for the scratch store and general bridge control block.
// Assumes a 20 MHz system clock and a 32-bit serial frame per access.
package sbgc_pkg;

   // Clock and charge pump modulation timing
   localparam int CLK_HZ          = 20000000;
   localparam int MOD_FREQ_DHZ    = 156000;   // 15.6 kHz in tenths of a hertz
   localparam int MOD_CYCLES      = (CLK_HZ * 10) / MOD_FREQ_DHZ;

   // Serial frame layout, first bit on the wire is bit 0
   localparam int FRAME_BITS      = 32;
   localparam int ADDR_LSB        = 0;
   localparam int ADDR_W          = 7;
   localparam int WR_BIT          = 7;
   localparam int DATA_LSB        = 8;
   localparam int DATA_W          = 16;

   // Register addresses (7-bit frame address)
   localparam logic [6:0] BRIDGE_GENERAL_CONTROL_ADDR = 7'h10;
   localparam logic [6:0] HOST_SCRATCH_CONFIG_ADDR    = 7'h0F;

   // Values after power-on or soft reset
   localparam logic [15:0] BRIDGE_GENERAL_CONTROL_RST = 16'h0801;
   localparam logic [15:0] HOST_SCRATCH_CONFIG_RST    = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ              = 16'h0000;

   // Received frame
   typedef struct packed {
      logic [6:0]  addr;
      logic        wr;
      logic [15:0] data;
   } sbgc_frame_t;

   // General bridge control word, bit 15 first
   typedef struct packed {
      logic       sync_freq_select;
      logic       upper_pair_route;
      logic       lower_pair_route;
      logic       pump_uv_threshold_sel;
      logic       mosfet_level_sel;
      logic       pump_stage_autoswitch;
      logic       overvoltage_recover_en;
      logic       precharge_step_adapt;
      logic [1:0] adaptive_gate_field;
      logic       pump_enable;
      logic       postcharge_disable;
      logic       adaptive_gate_filter;
      logic       active_fw_detect_en;
      logic       gate_hold_current_sel;
      logic       pump_freq_modulation;
   } sbgc_bridge_general_control_t;

endpackage

// ---- rtl/sbgc_pwm_route.sv ----
// Routes the four PWM inputs to the four half-bridges.
// Assumes PWM inputs are synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module sbgc_pwm_route
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic upper_pair_route,
   input  wire logic lower_pair_route,
   input  wire logic pwm_input_one,
   input  wire logic pwm_input_two,
   input  wire logic pwm_input_three,
   input  wire logic pwm_input_four,
   output logic      half_bridge_one,
   output logic      half_bridge_two,
   output logic      half_bridge_three,
   output logic      half_bridge_four
);
   // Selection; a bridge left without a source is held low
   wire next_hb1 = lower_pair_route ? 1'b0 : pwm_input_one;
   wire next_hb2 = lower_pair_route ? pwm_input_one : pwm_input_two;
   wire next_hb3 = upper_pair_route ? 1'b0 : pwm_input_three;
   wire next_hb4 = upper_pair_route ? pwm_input_three : pwm_input_four;

   // Registered bridge commands
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         half_bridge_one   <= 1'b0;
         half_bridge_two   <= 1'b0;
         half_bridge_three <= 1'b0;
         half_bridge_four  <= 1'b0;
      end
      else
      begin
         half_bridge_one   <= next_hb1;
         half_bridge_two   <= next_hb2;
         half_bridge_three <= next_hb3;
         half_bridge_four  <= next_hb4;
      end
   end
endmodule // sbgc_pwm_route
`default_nettype wire

// ---- rtl/sbgc_spi_shift.sv ----
// Serial frame shifter: captures 32-bit frames, shifts read data out.
// Assumes sclk, csn and sdi are synchronous to clk_sys and much slower.
`timescale 1ns/100ps
`default_nettype none
module sbgc_spi_shift
   import sbgc_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                sclk,
   input  wire logic                csn,
   input  wire logic                sdi,
   input  wire logic [15:0]         rd_data,
   output logic                     sdo,
   output logic [6:0]               cur_addr,
   output logic                     frame_valid,
   output sbgc_pkg::sbgc_frame_t    frame
);
   logic        sclk_d;
   logic        csn_d;
   logic [31:0] rx;
   logic [5:0]  bit_cnt;
   logic [15:0] tx;
   wire         rise    = sclk & ~sclk_d & ~csn;
   wire         fall    = ~sclk & sclk_d & ~csn;
   wire         cs_end  = csn & ~csn_d;
   wire         full    = (bit_cnt == 6'(FRAME_BITS));

   // Bits enter at the top, so after the command byte the address sits at bit 24
   assign cur_addr = rx[(FRAME_BITS - DATA_LSB + ADDR_LSB) +: ADDR_W];
   assign sdo      = tx[0];

   // Shift in on rising edge, out on falling edge; close frame on deselect
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sclk_d      <= 1'b0;
         csn_d       <= 1'b1;
         rx          <= 32'h0;
         bit_cnt     <= 6'h0;
         tx          <= 16'h0;
         frame_valid <= 1'b0;
         frame       <= '0;
      end
      else
      begin
         sclk_d      <= sclk;
         csn_d       <= csn;
         frame_valid <= cs_end & full;   // Short frames are dropped; bits after the 32nd are ignored
         if (cs_end)
            frame <= {rx[ADDR_LSB +: ADDR_W], rx[WR_BIT], rx[DATA_LSB +: DATA_W]};
         if (csn)
            bit_cnt <= 6'h0;
         else if (rise && !full)
         begin
            rx      <= {sdi, rx[31:1]};
            bit_cnt <= bit_cnt + 6'h1;
         end
         if (fall && bit_cnt == 6'(DATA_LSB))
            tx <= rd_data;
         else if (fall && bit_cnt > 6'(DATA_LSB))
            tx <= {1'b0, tx[15:1]};
      end
   end
endmodule // sbgc_spi_shift
`default_nettype wire

// ---- rtl/sbgc_top.sv ----
// Scratch store and general bridge control registers behind the serial port.
// Assumes serial pins and mode inputs are synchronous to clk_sys; rst_n is
// the power-on reset and soft_reset a one-cycle request from the mode logic.
//
// Overview of operation
// - Sixteen-bit host read/write scratch store with no effect on device behaviour.
// - Power-on and soft reset clear the scratch store to zero.
// - Scratch store is reachable only in Normal Mode; host must not expect otherwise.
// - Fail-Safe or Restart Mode entry leaves the scratch store untouched.
// - Only host writes change the scratch store; internal logic never does.
// - Bit 15 selects sync frequency: 0 gives 18.75 MHz, 1 gives 37.5 MHz.
// - Bit 14: 0 routes PWM_INPUT_THREE and PWM_INPUT_FOUR straight, 1 routes PWM_INPUT_THREE to bridge four.
// - Bit 13: 0 routes PWM_INPUT_ONE and PWM_INPUT_TWO straight, 1 routes PWM_INPUT_ONE to bridge two.
// - Bit 12 selects pump undervoltage threshold one or two, with MOSFET level.
// - Bit 11 selects logic-level MOSFETs at 0, normal level at 1 (default).
// - Bit 10 enables automatic dual/single pump stage switchover when set.
// - Bit 9 lets the bridge driver recover after overvoltage when set.
// - Bit 8 adapts precharge current by one step at 0, two steps at 1.
// - Bit 5 switches the charge pump on when set.
// - Bit 4 suppresses the postcharge phase during PWM when set.
// - Bit 3 applies the adaptive gate control filter when set.
// - Bit 2 enables active/freewheeling MOSFET detection when set.
// - Bit 1 selects the higher gate hold current when set.
// - Bit 0 enables 15.6 kHz pump modulation; set after reset.
// - Reserved and unmapped bits read back as zero.
`timescale 1ns/100ps
`default_nettype none
module sbgc_top
   import sbgc_pkg::*;
#(
   parameter int MOD_DIV = sbgc_pkg::MOD_CYCLES
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             soft_reset,
   input  wire logic             normal_mode,
   input  wire logic             sclk,
   input  wire logic             csn,
   input  wire logic             sdi,
   output logic                  sdo,
   output logic                  sdo_oe_n,
   input  wire logic             pwm_input_one,
   input  wire logic             pwm_input_two,
   input  wire logic             pwm_input_three,
   input  wire logic             pwm_input_four,
   output logic                  half_bridge_one,
   output logic                  half_bridge_two,
   output logic                  half_bridge_three,
   output logic                  half_bridge_four,
   output sbgc_pkg::sbgc_bridge_general_control_t bridge_cfg,
   output logic                  sync_fast,
   output logic                  pump_uv_th2,
   output logic                  pump_on,
   output logic                  pump_mod_tick,
   output logic [15:0]           scratch_config_bits
);
   import sbgc_pkg::*;

   // Register storage
   logic [15:0]   host_scratch_config;
   sbgc_bridge_general_control_t bridge_general_control;

   // Frame interface
   logic          frame_valid;
   sbgc_frame_t   frame;
   logic [6:0]    cur_addr;
   logic [15:0]   rd_data;

   // Modulation divider
   logic [15:0]   mod_cnt;

   // Serial frame capture and read data shift-out
   sbgc_spi_shift u_shift
   (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .sclk        (sclk),
      .csn         (csn),
      .sdi         (sdi),
      .rd_data     (rd_data),
      .sdo         (sdo),
      .cur_addr    (cur_addr),
      .frame_valid (frame_valid),
      .frame       (frame)
   );

   // Data output is driven only while the frame is selected
   assign sdo_oe_n = csn;

   // Address decode of the completed frame
   wire hit_gen     = (frame.addr == BRIDGE_GENERAL_CONTROL_ADDR);
   wire hit_scratch = (frame.addr == HOST_SCRATCH_CONFIG_ADDR) & normal_mode;
   wire wr_gen      = frame_valid & frame.wr & hit_gen;
   wire wr_scratch  = frame_valid & frame.wr & hit_scratch;

   // Read decode of the address being shifted in
   wire rd_gen      = (cur_addr == BRIDGE_GENERAL_CONTROL_ADDR);
   wire rd_scratch  = (cur_addr == HOST_SCRATCH_CONFIG_ADDR) & normal_mode;

   // Read data multiplexer; anything else returns zeros
   assign rd_data = rd_gen     ? 16'(bridge_general_control) :
                    rd_scratch ? host_scratch_config :
                    UNMAPPED_READ;

   // Scratch store: cleared only by power-on or soft reset,
   // and changed by nothing but a host write
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || soft_reset)
         host_scratch_config <= HOST_SCRATCH_CONFIG_RST;
      else if (wr_scratch)
         host_scratch_config <= frame.data;
   end
   // Fail-Safe and Restart have no path into this register

   // Bridge control word; every field stored as written
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || soft_reset)
         bridge_general_control <= sbgc_bridge_general_control_t'(BRIDGE_GENERAL_CONTROL_RST);
      else if (wr_gen)
         bridge_general_control <= sbgc_bridge_general_control_t'(frame.data);
   end

   // Field outputs to the analogue bridge driver
   assign bridge_cfg          = bridge_general_control;
   assign sync_fast           = bridge_general_control.sync_freq_select;
   assign pump_uv_th2         = bridge_general_control.pump_uv_threshold_sel;
   assign pump_on             = bridge_general_control.pump_enable;
   assign scratch_config_bits = host_scratch_config;

   // Bridge gate options pass through the config word unchanged

   // Pump modulation tick divider, runs only with the pump on and
   // modulation selected
   wire mod_run  = bridge_general_control.pump_freq_modulation &
                   bridge_general_control.pump_enable;
   wire mod_wrap = (mod_cnt == 16'(MOD_DIV - 1));

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !mod_run)
      begin
         mod_cnt       <= 16'h0;
         pump_mod_tick <= 1'b0;
      end
      else
      begin
         mod_cnt       <= mod_wrap ? 16'h0 : mod_cnt + 16'h1;
         pump_mod_tick <= mod_wrap;
      end
   end

   // PWM input to half-bridge routing
   sbgc_pwm_route u_route
   (
      .clk_sys           (clk_sys),
      .rst_n             (rst_n),
      .upper_pair_route  (bridge_general_control.upper_pair_route),
      .lower_pair_route  (bridge_general_control.lower_pair_route),
      .pwm_input_one     (pwm_input_one),
      .pwm_input_two     (pwm_input_two),
      .pwm_input_three   (pwm_input_three),
      .pwm_input_four    (pwm_input_four),
      .half_bridge_one   (half_bridge_one),
      .half_bridge_two   (half_bridge_two),
      .half_bridge_three (half_bridge_three),
      .half_bridge_four  (half_bridge_four)
   );
endmodule // sbgc_top
`default_nettype wire

// ---- testbench/sbgc_host_model.sv ----
// Host model: sends 32-bit frames LSB first and captures read data.
// Assumes inputs change at clk_sys falling edges, sclk phases two cycles.
`timescale 1ns/100ps
`default_nettype none
module sbgc_host_model
(
   input  wire logic        clk_sys,
   input  wire logic        sdo,
   output logic             sclk,
   output logic             csn,
   output logic             sdi,
   output logic [15:0]      rd_val,
   output logic             rd_tgl = 1'b0
);
   // Idle lines: data toggles while deselected, clock stands low
   initial
   begin
      sclk = 1'b0;
      csn = 1'b1;
      sdi = 1'b0;
   end
   always @(negedge clk_sys)
      if (csn) sdi <= ~sdi;
   // One whole frame; read data taken at clock rises 9 to 24
   task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d);
      logic [31:0] f;
      f = {8'h00, d, w, a};
      csn = 1'b0;
      @(negedge clk_sys);
      for (int i = 0; i < 32; i++)
      begin
         sdi = f[i];
         repeat (2) @(negedge clk_sys);
         if (i >= 8 && i < 24) rd_val[i-8] = sdo;
         sclk = 1'b1;
         repeat (2) @(negedge clk_sys);
         sclk = 1'b0;
      end
      repeat (2) @(negedge clk_sys);
      csn = 1'b1;
      repeat (3) @(negedge clk_sys);
      if (!w) rd_tgl = ~rd_tgl;
   endtask
endmodule // sbgc_host_model
`default_nettype wire

// ---- testbench/sbgc_top_checker.sv ----
// Checker bound into sbgc_top: timing of register, routing and tick outputs.
// Assumes all inputs are synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module sbgc_top_checker
#(
   parameter int MOD_DIV = 8
)
(
   input wire logic                    clk_sys,
   input wire logic                    rst_n,
   input wire logic                    soft_reset,
   input wire logic                    csn,
   input wire logic                    sdo_oe_n,
   input wire logic                    pwm_input_one,
   input wire logic                    pwm_input_two,
   input wire logic                    pwm_input_three,
   input wire logic                    pwm_input_four,
   input wire logic                    half_bridge_one,
   input wire logic                    half_bridge_two,
   input wire logic                    half_bridge_three,
   input wire logic                    half_bridge_four,
   input wire sbgc_pkg::sbgc_bridge_general_control_t bridge_cfg,
   input wire logic                    sync_fast,
   input wire logic                    pump_uv_th2,
   input wire logic                    pump_on,
   input wire logic                    pump_mod_tick,
   input wire logic [15:0]             scratch_config_bits
);
   import sbgc_pkg::*;
   int gap;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // Host quiet long enough that no commit can land
   sequence s_quiet;
      (csn && !soft_reset)[*4];
   endsequence
   // Cycles since the last modulation tick
   always_ff @(posedge clk_sys)
      gap <= !rst_n ? MOD_DIV : (pump_mod_tick ? 1 : gap + 1);
   // Register and output relations
   a_soft_clear: assert property (soft_reset |=> bridge_cfg == BRIDGE_GENERAL_CONTROL_RST
      && scratch_config_bits == 16'h0000) else $error("soft reset did not clear");
   a_scratch_hold: assert property (s_quiet |-> $stable(scratch_config_bits))
      else $error("scratch changed without a host write");
   a_cfg_hold: assert property (s_quiet |-> $stable(bridge_cfg))
      else $error("control word changed without a host write");
   a_freq_out: assert property (sync_fast == bridge_cfg.sync_freq_select)
      else $error("sync select output wrong");
   a_oe_select: assert property (sdo_oe_n == csn)
      else $error("data output enable does not follow select");
   a_pump_outs: assert property (pump_on == bridge_cfg.pump_enable
      && pump_uv_th2 == bridge_cfg.pump_uv_threshold_sel) else $error("pump outputs wrong");
   a_low_route: assert property ($past(rst_n) |->
      half_bridge_one == ($past(pwm_input_one) && !$past(bridge_cfg.lower_pair_route))
      && half_bridge_two == ($past(bridge_cfg.lower_pair_route) ? $past(pwm_input_one)
      : $past(pwm_input_two))) else $error("lower pair routing wrong");
   a_high_route: assert property ($past(rst_n) |->
      half_bridge_three == ($past(pwm_input_three) && !$past(bridge_cfg.upper_pair_route))
      && half_bridge_four == ($past(bridge_cfg.upper_pair_route) ? $past(pwm_input_three)
      : $past(pwm_input_four))) else $error("upper pair routing wrong");
   a_tick_gap: assert property (pump_mod_tick |-> gap >= MOD_DIV)
      else $error("modulation ticks too close");
   a_tick_off: assert property ((!(pump_on && bridge_cfg.pump_freq_modulation))[*2]
      |-> !pump_mod_tick) else $error("tick while modulation off");
endmodule // sbgc_top_checker
bind sbgc_top sbgc_top_checker #(.MOD_DIV(MOD_DIV)) u_chk (.clk_sys, .rst_n, .soft_reset,
   .csn, .sdo_oe_n, .pwm_input_one, .pwm_input_two, .pwm_input_three, .pwm_input_four,
   .half_bridge_one, .half_bridge_two, .half_bridge_three, .half_bridge_four,
   .bridge_cfg, .sync_fast, .pump_uv_th2, .pump_on, .pump_mod_tick, .scratch_config_bits);
`default_nettype wire

// ---- testbench/sbgc_top_tb_top.sv ----
// Testbench for sbgc_top: readback, mode gating, soft reset, routing, ticks.
// Assumes sbgc_host_model plays the host on the serial pins.
`timescale 1ns/100ps
`default_nettype none
module sbgc_top_tb_top;
   import sbgc_pkg::*;
   logic          clk_sys = 1'b0, rst_n, soft_reset, normal_mode, sclk, csn, sdi, sdo;
   logic          sync_fast, pump_uv_th2, pump_on, tick, rd_tgl;
   logic [3:0]    pwm, hb;
   logic [15:0]   scratch, rd_val, v;
   logic [15:0]   exp_q[$];
   sbgc_bridge_general_control_t cfg;
   int            n_mismatch = 0, checks_done = 0, cyc = 0, ticks;
   localparam logic [6:0] CA = BRIDGE_GENERAL_CONTROL_ADDR, SA = HOST_SCRATCH_CONFIG_ADDR;
   sbgc_top #(.MOD_DIV(8)) dut_u (.clk_sys, .rst_n, .soft_reset, .normal_mode, .sclk, .csn,
      .sdi, .sdo, .sdo_oe_n(), .pwm_input_one(pwm[0]), .pwm_input_two(pwm[1]),
      .pwm_input_three(pwm[2]), .pwm_input_four(pwm[3]), .half_bridge_one(hb[0]),
      .half_bridge_two(hb[1]), .half_bridge_three(hb[2]), .half_bridge_four(hb[3]),
      .bridge_cfg(cfg), .sync_fast, .pump_uv_th2, .pump_on, .pump_mod_tick(tick),
      .scratch_config_bits(scratch));
   sbgc_host_model u_host (.clk_sys, .sdo, .sclk, .csn, .sdi, .rd_val, .rd_tgl);
   // Clock and hang limit
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         results();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Each finished read is compared with the oldest note
   initial forever
   begin
      @(rd_tgl);
      check(rd_val, exp_q.pop_front());
   end
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_host.xfer(a, 1'b0, 16'h0000);
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      u_host.xfer(a, 1'b1, d);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      v = $urandom(42);
      {rst_n, soft_reset, normal_mode, pwm} = 7'h14;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check(cfg, BRIDGE_GENERAL_CONTROL_RST);
      rd(CA, 16'h0801);
      rd(SA, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 16; i++)
      begin
         v = 16'h0001 << i;
         wr(CA, v);
         check(cfg, v);
         check({13'h0, sync_fast, pump_uv_th2, pump_on}, {13'h0, v[15], v[12], v[5]});
         rd(CA, v);
      end
      $display("test control word done");
      for (int i = 0; i < 4; i++)
      begin
         v = 16'($urandom);
         wr(SA, v);
         check(scratch, v);
         rd(SA, v);
      end
      normal_mode = 1'b0;
      wr(SA, ~v);
      check(scratch, v);
      rd(SA, 16'h0000);
      normal_mode = 1'b1;
      rd(SA, v);
      wr(7'h3A, 16'hFFFF);
      rd(7'h3A, 16'h0000);
      check(cfg, 16'h8000);
      $display("test scratch and mode done");
      soft_reset = 1'b1;
      @(negedge clk_sys);
      soft_reset = 1'b0;
      @(negedge clk_sys);
      check(cfg, 16'h0801);
      check(scratch, 16'h0000);
      $display("test soft reset done");
      for (int m = 0; m < 4; m++)
      begin
         wr(CA, {1'b0, 2'(m), 13'h0801});
         repeat (8)
         begin
            pwm = 4'($urandom);
            @(negedge clk_sys);
            check({12'h0, hb}, {12'h0, m[1] ? pwm[2] : pwm[3], pwm[2] & ~m[1],
               m[0] ? pwm[0] : pwm[1], pwm[0] & ~m[0]});
         end
      end
      $display("test routing done");
      for (int k = 0; k < 2; k++)
      begin
         wr(CA, k ? 16'h0801 : 16'h0821);
         repeat (10) @(negedge clk_sys);
         ticks = 0;
         repeat (80)
         begin
            @(negedge clk_sys);
            if (tick === 1'b1) ticks++;
         end
         check(16'(ticks), k ? 16'h0000 : 16'h000A);
      end
      $display("test modulation done");
      @(negedge clk_sys);
      results();
   end
endmodule // sbgc_top_tb_top
`default_nettype wire
